/* qwdp_regs.vh */
`ifndef QWDP_REGS_VH
`define QWDP_REGS_VH

// wiper register width and power-up tap (mid-scale)
`define QWDP_WIPER_W     6
`define QWDP_WIPER_INIT  6'h20

// data byte layout: pot index on top, position below
`define QWDP_BYTE_W      8
`define QWDP_POS_HI      5
`define QWDP_POS_LO      0
`define QWDP_SEL_HI      7
`define QWDP_SEL_LO      6
`define QWDP_SEL_W       2
`define QWDP_POT0        2'h0
`define QWDP_POT_LAST    2'h3

// command/control byte layout
`define QWDP_TYPE_HI     7
`define QWDP_TYPE_LO     4
`define QWDP_ADDR_HI     3
`define QWDP_ADDR_LO     1
`define QWDP_RW_BIT      0

// device-type code, value is arbitrary
`define QWDP_DEV_TYPE    4'hA

// bit counting within a byte
`define QWDP_CNT_W       3
`define QWDP_CNT_ZERO    3'h0
`define QWDP_LAST_BIT    3'h7

// write fifo
`define QWDP_FIFO_DEPTH  8
`define QWDP_FIFO_AW     3

// synchronised pin vector positions
`define QWDP_NPIN        10
`define QWDP_PIN_PSEL    0
`define QWDP_PIN_STB     1
`define QWDP_PIN_SCK     2
`define QWDP_PIN_DIN     3
`define QWDP_PIN_DIR     4
`define QWDP_PIN_SCL     5
`define QWDP_PIN_SDA     6
`define QWDP_PIN_ADR_LO  7
`define QWDP_PIN_ADR_HI  9

`endif

/* qwdp_fifo.v */
`timescale 1ns/100ps
module qwdp_fifo
#(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW    = 3
)
(
  input  wire             CORE_CLK,
  input  wire             RST,
  input  wire             IN_VALID,
  output wire             IN_READY,
  input  wire [WIDTH-1:0] IN_DATA,
  output wire             OUT_VALID,
  input  wire             OUT_READY,
  output wire [WIDTH-1:0] OUT_DATA
);

  // last slot index and full count at pointer widths
  localparam [AW-1:0] LAST     = DEPTH[AW-1:0] - 1'b1;
  localparam [AW:0]   FULL_CNT = DEPTH[AW:0];

  reg [WIDTH-1:0] mem [0:DEPTH-1]; // storage words
  reg [AW-1:0]    wr_ptr;          // next slot to fill
  reg [AW-1:0]    rd_ptr;          // oldest word
  reg [AW:0]      count;           // words held

  wire do_wr; // word accepted
  wire do_rd; // word drained

  // honest flags straight from the count
  assign IN_READY  = (count != FULL_CNT);
  assign OUT_VALID = (count != {(AW+1){1'b0}});
  assign OUT_DATA  = mem[rd_ptr];
  assign do_wr     = IN_VALID & IN_READY;
  assign do_rd     = OUT_VALID & OUT_READY;

  // storage write, no reset needed on data
  always @(posedge CORE_CLK)
  begin
    if (do_wr)
    begin
      mem[wr_ptr] <= IN_DATA;
    end
  end

  // pointers and count
  always @(posedge CORE_CLK)
  begin
    if (RST)
    begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count  <= {(AW+1){1'b0}};
    end
    else
    begin
      // wrap at the last slot, depth need not be a power of two
      if (do_wr)
      begin
        wr_ptr <= (wr_ptr == LAST) ? {AW{1'b0}} : wr_ptr + 1'b1;
      end
      if (do_rd)
      begin
        rd_ptr <= (rd_ptr == LAST) ? {AW{1'b0}} : rd_ptr + 1'b1;
      end
      // simultaneous fill and drain leaves the count alone
      if (do_wr & ~do_rd)
      begin
        count <= count + 1'b1;
      end
      else if (do_rd & ~do_wr)
      begin
        count <= count - 1'b1;
      end
    end
  end

endmodule

/* qwdp_top.v */
// Summary of operation
// - four separate 6-bit wiper registers drive taps
// - every wiper starts at position 32
// - byte: pot index top two, position low
// - select pin low shift port, high two-wire
// - strobe rise starts, strobe fall ends transaction
// - direction captured at strobe rise only
// - write samples data on shift clock rise
// - byte loads wiper on eighth clock fall
// - one or more bytes, any pot order
// - cascade inhibited on write, passthrough when idle, held low in two-wire mode
// - read shifts pots out msb first, ascending
// - start and stop from data edge, clock high
// - data changes only while bus clock low
// - eight-bit bytes, ninth bit acknowledges
// - acknowledge holds data low through clock high
// - missing master acknowledge releases data line
// - write: control byte, data bytes, all acked
// - read: control acked, then data bytes sent
// - no limit on bytes per transfer
// - stop or repeated start ends the transfer
// - works at standard and fast bus rates
// - control byte: type, select bits, direction
// - two-wire write updates wiper on acknowledge
// - two-wire read returns pot 0 upward
`timescale 1ns/100ps
`include "qwdp_regs.vh"
module qwdp_top
#(
  parameter                  FIFO_DEPTH = `QWDP_FIFO_DEPTH,
  parameter                  FIFO_AW    = `QWDP_FIFO_AW,
  parameter [`QWDP_TYPE_HI-`QWDP_TYPE_LO:0]
                             DEV_TYPE   = `QWDP_DEV_TYPE
)
(
  input  wire                    CORE_CLK,
  input  wire                    RST,
  input  wire                    PORT_SELECT_PIN,
  input  wire                    XFER_STROBE,
  input  wire                    SHIFT_CLK,
  input  wire                    SER_DIN,
  input  wire                    DIR_READ,
  output reg                     SER_DOUT,
  input  wire                    SCL_IN,
  input  wire                    SDA_IN,
  output wire                    SDA_OUT,
  output reg                     SDA_OE,
  input  wire                    DEVICE_SELECT_BIT0,
  input  wire                    DEVICE_SELECT_BIT1,
  input  wire                    DEVICE_SELECT_BIT2,
  output wire [`QWDP_WIPER_W-1:0] WIPER0,
  output wire [`QWDP_WIPER_W-1:0] WIPER1,
  output wire [`QWDP_WIPER_W-1:0] WIPER2,
  output wire [`QWDP_WIPER_W-1:0] WIPER3
);

  // two-wire fsm states
  localparam [2:0] TW_IDLE   = 3'h0; // bus free or other port
  localparam [2:0] TW_ADDR   = 3'h1; // taking control byte
  localparam [2:0] TW_WDATA  = 3'h2; // taking a data byte
  localparam [2:0] TW_ACK    = 3'h3; // driving our acknowledge
  localparam [2:0] TW_TX     = 3'h4; // sending a wiper byte
  localparam [2:0] TW_RACK   = 3'h5; // master acknowledge slot
  localparam [2:0] TW_IGNORE = 3'h6; // not ours, wait for start

  // pin synchronisers and filtered levels
  wire [`QWDP_NPIN-1:0] pin_raw;  // raw pins, one vector
  reg  [`QWDP_NPIN-1:0] sync1;    // first stage, read by sync2 only
  reg  [`QWDP_NPIN-1:0] sync2;    // second stage
  reg  [`QWDP_NPIN-1:0] sync3;    // third stage
  reg  [`QWDP_NPIN-1:0] pin;      // accepted level
  reg  [`QWDP_NPIN-1:0] pin_d;    // accepted level, one cycle old
  wire [`QWDP_NPIN-1:0] agree;    // stages two and three match

  // decoded pin levels and edges
  wire two_wire;   // port select high
  wire stb;        // strobe level
  wire stb_rise;   // strobe went high
  wire sck_rise;   // shift clock rising
  wire sck_fall;   // shift clock falling
  wire din;        // shift data in
  wire scl;        // bus clock level
  wire sda;        // bus data level
  wire scl_rise;   // bus clock rising
  wire scl_fall;   // bus clock falling
  wire bus_start;  // start or repeated start
  wire bus_stop;   // stop condition
  wire [`QWDP_ADDR_HI-`QWDP_ADDR_LO:0] dev_sel; // select straps

  // wiper storage
  reg [`QWDP_WIPER_W-1:0] wiper [0:`QWDP_POT_LAST];

  // shift port state
  reg                     sw_read;   // captured direction
  reg [`QWDP_CNT_W:0]     sw_cnt;    // rising edges in this byte
  reg                     sw_full;   // eight bits assembled
  reg [`QWDP_BYTE_W-1:0]  sw_shift;  // incoming byte
  reg [`QWDP_BYTE_W-1:0]  rd_shift;  // outgoing byte
  reg [`QWDP_CNT_W-1:0]   rd_cnt;    // bits sent of this byte
  reg [`QWDP_SEL_W-1:0]   rd_pot;    // pot being sent
  wire                    sw_write;  // active write transaction
  wire                    sw_rdact;  // active read transaction
  wire                    sw_push;   // byte ready for wipers
  wire                    sw_load;   // read loads a wiper byte
  wire [`QWDP_SEL_W-1:0]  rd_next;   // next pot in ascending order

  // two-wire state
  reg [2:0]               tw_state;  // fsm state
  reg [`QWDP_CNT_W-1:0]   tw_cnt;    // bit position
  reg                     tw_done;   // eight bits taken
  reg [`QWDP_BYTE_W-1:0]  tw_shift;  // incoming byte
  reg [`QWDP_BYTE_W-1:0]  tx_shift;  // outgoing remainder
  reg                     tw_read;   // direction of transfer
  reg                     tw_acked;  // master acknowledged
  reg [`QWDP_SEL_W-1:0]   tw_pot;    // next pot to send
  wire                    tw_match;  // control byte is ours
  wire                    tw_push;   // data byte accepted
  wire                    tw_load;   // read loads a wiper byte
  wire [`QWDP_BYTE_W-1:0] tw_byte;   // byte for tw_pot

  // fifo between ports and wipers
  wire                    fifo_in_valid;
  wire                    fifo_in_ready;
  wire [`QWDP_BYTE_W-1:0] fifo_in_data;
  wire                    fifo_out_valid;
  wire                    fifo_out_ready;
  wire [`QWDP_BYTE_W-1:0] fifo_out_data;

  assign pin_raw = {DEVICE_SELECT_BIT2, DEVICE_SELECT_BIT1,
                    DEVICE_SELECT_BIT0, SDA_IN, SCL_IN, DIR_READ,
                    SER_DIN, SHIFT_CLK, XFER_STROBE, PORT_SELECT_PIN};
  assign agree   = ~(sync2 ^ sync3);

  // three-stage sync; a level counts once stages two and three agree
  always @(posedge CORE_CLK)
  begin
    if (RST)
    begin
      sync1 <= {`QWDP_NPIN{1'b0}};
      sync2 <= {`QWDP_NPIN{1'b0}};
      sync3 <= {`QWDP_NPIN{1'b0}};
      pin   <= {`QWDP_NPIN{1'b0}};
      pin_d <= {`QWDP_NPIN{1'b0}};
    end
    else
    begin
      // sampled at 100 MHz, far above the fast bus rate
      sync1 <= pin_raw;
      sync2 <= sync1;
      sync3 <= sync2;
      pin   <= (pin & ~agree) | (sync3 & agree);
      pin_d <= pin;
    end
  end

  // level and edge decode from the accepted levels
  assign two_wire = pin[`QWDP_PIN_PSEL];
  assign stb      = pin[`QWDP_PIN_STB];
  assign stb_rise = stb & ~pin_d[`QWDP_PIN_STB];
  assign sck_rise = pin[`QWDP_PIN_SCK] & ~pin_d[`QWDP_PIN_SCK];
  assign sck_fall = ~pin[`QWDP_PIN_SCK] & pin_d[`QWDP_PIN_SCK];
  assign din      = pin[`QWDP_PIN_DIN];
  assign scl      = pin[`QWDP_PIN_SCL];
  assign sda      = pin[`QWDP_PIN_SDA];
  assign scl_rise = scl & ~pin_d[`QWDP_PIN_SCL];
  assign scl_fall = ~scl & pin_d[`QWDP_PIN_SCL];
  assign dev_sel  = pin[`QWDP_PIN_ADR_HI:`QWDP_PIN_ADR_LO];

  // data edge while clock stays high marks a bus condition
  assign bus_start = scl & pin_d[`QWDP_PIN_SCL] &
                     ~sda & pin_d[`QWDP_PIN_SDA];
  assign bus_stop  = scl & pin_d[`QWDP_PIN_SCL] &
                     sda & ~pin_d[`QWDP_PIN_SDA];

  // shift port is live only with select low and strobe high
  assign sw_write = ~two_wire & stb & ~stb_rise & ~sw_read;
  assign sw_rdact = ~two_wire & stb & ~stb_rise & sw_read;
  // eighth falling edge hands the byte over
  assign sw_push  = sw_write & sck_fall & sw_full;
  assign rd_next  = rd_pot + 1'b1;
  // read fetches pot 0 at the strobe, then on each byte end
  assign sw_load  = (~two_wire & stb_rise & pin[`QWDP_PIN_DIR]) |
                    (sw_rdact & sck_fall & (rd_cnt == `QWDP_LAST_BIT));

  // shift port write side and direction capture
  always @(posedge CORE_CLK)
  begin
    if (RST | two_wire | ~stb)
    begin
      // strobe low disables the port
      sw_read  <= 1'b0;
      sw_cnt   <= {(`QWDP_CNT_W+1){1'b0}};
      sw_full  <= 1'b0;
      sw_shift <= {`QWDP_BYTE_W{1'b0}};
    end
    else if (stb_rise)
    begin
      // direction frozen for the whole transaction
      sw_read <= pin[`QWDP_PIN_DIR];
      sw_cnt  <= {(`QWDP_CNT_W+1){1'b0}};
      sw_full <= 1'b0;
    end
    else if (sw_write)
    begin
      if (sck_rise & ~sw_full)
      begin
        // msb first, one bit per rising edge
        sw_shift <= {sw_shift[`QWDP_BYTE_W-2:0], din};
        sw_cnt   <= sw_cnt + 1'b1;
        if (sw_cnt[`QWDP_CNT_W-1:0] == `QWDP_LAST_BIT)
        begin
          sw_full <= 1'b1;
        end
      end
      else if (sw_push)
      begin
        // next byte of a longer write starts clean
        sw_full <= 1'b0;
        sw_cnt  <= {(`QWDP_CNT_W+1){1'b0}};
      end
    end
  end

  // shift port read side
  always @(posedge CORE_CLK)
  begin
    if (RST | two_wire)
    begin
      rd_shift <= {`QWDP_BYTE_W{1'b0}};
      rd_cnt   <= `QWDP_CNT_ZERO;
      rd_pot   <= `QWDP_POT0;
    end
    else if (stb_rise)
    begin
      // read always begins with pot 0
      rd_shift <= {`QWDP_POT0, wiper[`QWDP_POT0]};
      rd_cnt   <= `QWDP_CNT_ZERO;
      rd_pot   <= `QWDP_POT0;
    end
    else if (sw_rdact & sck_fall)
    begin
      rd_cnt <= rd_cnt + 1'b1;
      if (rd_cnt == `QWDP_LAST_BIT)
      begin
        // ascend to the next pot
        rd_shift <= {rd_next, wiper[rd_next]};
        rd_pot   <= rd_next;
      end
      else
      begin
        rd_shift <= {rd_shift[`QWDP_BYTE_W-2:0], 1'b0};
      end
    end
  end

  // cascade output select
  always @(posedge CORE_CLK)
  begin
    if (RST | two_wire)
    begin
      SER_DOUT <= 1'b0;
    end
    else if (~stb)
    begin
      // idle port passes data straight through
      SER_DOUT <= din;
    end
    else if (~sw_read)
    begin
      // write in progress keeps the cascade quiet
      SER_DOUT <= 1'b0;
    end
    else if (sw_rdact & sck_fall)
    begin
      // new bit appears at each falling edge
      SER_DOUT <= rd_shift[`QWDP_BYTE_W-1];
    end
  end

  // control byte decode on type code and straps, not direction
  assign tw_match = (tw_shift[`QWDP_TYPE_HI:`QWDP_TYPE_LO] == DEV_TYPE) &
                    (tw_shift[`QWDP_ADDR_HI:`QWDP_ADDR_LO] == dev_sel);
  assign tw_byte  = {tw_pot, wiper[tw_pot]};
  // data byte is taken at the acknowledge decision
  assign tw_push  = two_wire & (tw_state == TW_WDATA) & scl_fall &
                    tw_done & fifo_in_ready;
  assign tw_load  = two_wire & scl_fall &
                    (((tw_state == TW_ACK) & tw_read) |
                     ((tw_state == TW_RACK) & tw_acked));
  // open drain: only ever pulls low
  assign SDA_OUT  = 1'b0;

  // two-wire slave fsm, all sda moves follow a clock fall
  always @(posedge CORE_CLK)
  begin
    if (RST | ~two_wire)
    begin
      tw_state <= TW_IDLE;
      tw_cnt   <= `QWDP_CNT_ZERO;
      tw_done  <= 1'b0;
      tw_shift <= {`QWDP_BYTE_W{1'b0}};
      tx_shift <= {`QWDP_BYTE_W{1'b0}};
      tw_read  <= 1'b0;
      tw_acked <= 1'b0;
      tw_pot   <= `QWDP_POT0;
      SDA_OE   <= 1'b0;
    end
    else if (bus_start)
    begin
      // repeated start ends the old transfer, decode anew
      tw_state <= TW_ADDR;
      tw_cnt   <= `QWDP_CNT_ZERO;
      tw_done  <= 1'b0;
      SDA_OE   <= 1'b0;
    end
    else if (bus_stop)
    begin
      tw_state <= TW_IDLE;
      SDA_OE   <= 1'b0;
    end
    else
    begin
      case (tw_state)
        TW_ADDR, TW_WDATA:
        begin
          if (scl_rise & ~tw_done)
          begin
            // eight bits per byte, msb first
            tw_shift <= {tw_shift[`QWDP_BYTE_W-2:0], sda};
            tw_cnt   <= tw_cnt + 1'b1;
            if (tw_cnt == `QWDP_LAST_BIT)
            begin
              tw_done <= 1'b1;
            end
          end
          else if (scl_fall & tw_done)
          begin
            tw_done <= 1'b0;
            if (tw_state == TW_ADDR)
            begin
              if (tw_match)
              begin
                // acknowledge own control byte
                SDA_OE   <= 1'b1;
                tw_read  <= tw_shift[`QWDP_RW_BIT];
                tw_pot   <= `QWDP_POT0;
                tw_state <= TW_ACK;
              end
              else
              begin
                // stay off the bus until next start
                tw_state <= TW_IGNORE;
              end
            end
            else if (fifo_in_ready)
            begin
              // acknowledge each data byte, no count limit
              SDA_OE   <= 1'b1;
              tw_state <= TW_ACK;
            end
            else
            begin
              // no room: withhold acknowledge, drop out
              tw_state <= TW_IGNORE;
            end
          end
        end
        TW_ACK:
        begin
          // low held from fall to fall spans clock high
          if (scl_fall)
          begin
            tw_cnt <= `QWDP_CNT_ZERO;
            if (tw_read)
            begin
              // first byte is pot 0, ascending after
              SDA_OE   <= ~tw_byte[`QWDP_BYTE_W-1];
              tx_shift <= {tw_byte[`QWDP_BYTE_W-2:0], 1'b0};
              tw_pot   <= tw_pot + 1'b1;
              tw_state <= TW_TX;
            end
            else
            begin
              SDA_OE   <= 1'b0;
              tw_state <= TW_WDATA;
            end
          end
        end
        TW_TX:
        begin
          if (scl_fall)
          begin
            if (tw_cnt == `QWDP_LAST_BIT)
            begin
              // free the line for the master's ninth bit
              SDA_OE   <= 1'b0;
              tw_state <= TW_RACK;
            end
            else
            begin
              SDA_OE   <= ~tx_shift[`QWDP_BYTE_W-1];
              tx_shift <= {tx_shift[`QWDP_BYTE_W-2:0], 1'b0};
              tw_cnt   <= tw_cnt + 1'b1;
            end
          end
        end
        TW_RACK:
        begin
          if (scl_rise)
          begin
            tw_acked <= ~sda;
          end
          else if (scl_fall)
          begin
            tw_cnt <= `QWDP_CNT_ZERO;
            if (tw_acked)
            begin
              // master wants more, send next pot
              SDA_OE   <= ~tw_byte[`QWDP_BYTE_W-1];
              tx_shift <= {tw_byte[`QWDP_BYTE_W-2:0], 1'b0};
              tw_pot   <= tw_pot + 1'b1;
              tw_state <= TW_TX;
            end
            else
            begin
              // no acknowledge: leave line high for stop
              SDA_OE   <= 1'b0;
              tw_state <= TW_IGNORE;
            end
          end
        end
        default:
        begin
          // idle or ignoring: line released
          SDA_OE <= 1'b0;
        end
      endcase
    end
  end

  // both ports feed one fifo, only one is live at a time
  assign fifo_in_valid  = sw_push | tw_push;
  assign fifo_in_data   = two_wire ? tw_shift : sw_shift;
  // drain pauses while a read fetches a wiper byte
  assign fifo_out_ready = ~(sw_load | tw_load);

  qwdp_fifo
  #(
    .WIDTH (`QWDP_BYTE_W),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  )
  u_fifo
  (
    .CORE_CLK  (CORE_CLK),
    .RST       (RST),
    .IN_VALID  (fifo_in_valid),
    .IN_READY  (fifo_in_ready),
    .IN_DATA   (fifo_in_data),
    .OUT_VALID (fifo_out_valid),
    .OUT_READY (fifo_out_ready),
    .OUT_DATA  (fifo_out_data)
  );

  // wiper registers: mid-scale at reset, select bits pick one
  always @(posedge CORE_CLK)
  begin
    if (RST)
    begin
      wiper[0] <= `QWDP_WIPER_INIT;
      wiper[1] <= `QWDP_WIPER_INIT;
      wiper[2] <= `QWDP_WIPER_INIT;
      wiper[3] <= `QWDP_WIPER_INIT;
    end
    else if (fifo_out_valid & fifo_out_ready)
    begin
      // only the addressed wiper changes, any order
      wiper[fifo_out_data[`QWDP_SEL_HI:`QWDP_SEL_LO]] <=
        fifo_out_data[`QWDP_POS_HI:`QWDP_POS_LO];
    end
  end

  // each wiper drives its own ladder tap
  assign WIPER0 = wiper[0];
  assign WIPER1 = wiper[1];
  assign WIPER2 = wiper[2];
  assign WIPER3 = wiper[3];

endmodule

/* qwdp_top_monitor.sv */
`timescale 1ns/100ps
`include "qwdp_regs.vh"
module qwdp_top_mon
(
  input wire                     CORE_CLK,
  input wire                     RST,
  input wire                     PORT_SELECT_PIN,
  input wire                     XFER_STROBE,
  input wire                     SHIFT_CLK,
  input wire                     SER_DIN,
  input wire                     DIR_READ,
  input wire                     SER_DOUT,
  input wire                     SCL_IN,
  input wire                     SDA_OE,
  input wire [`QWDP_WIPER_W-1:0] WIPER0,
  input wire [`QWDP_WIPER_W-1:0] WIPER1,
  input wire [`QWDP_WIPER_W-1:0] WIPER2,
  input wire [`QWDP_WIPER_W-1:0] WIPER3
);
  // all four wipers side by side
  wire [4*`QWDP_WIPER_W-1:0] wipers;
  // edges since reset, lets the pin sync settle
  reg  [3:0]                 up_cnt;
  assign wipers = {WIPER3, WIPER2, WIPER1, WIPER0};
  // saturating count after reset
  always @(posedge CORE_CLK)
    if (RST)
      up_cnt <= 4'h0;
    else if (up_cnt != 4'hF)
      up_cnt <= up_cnt + 4'h1;
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (RST);
  // shift port idle, data-in steady
  sequence s_idle;
    (!PORT_SELECT_PIN && !XFER_STROBE && $stable(SER_DIN)
      && up_cnt > 4'h8) [*6];
  endsequence
  // shift port open for loading
  sequence s_load;
    (!PORT_SELECT_PIN && XFER_STROBE && !DIR_READ) [*6];
  endsequence
  // shift port open for reading
  sequence s_read;
    (!PORT_SELECT_PIN && XFER_STROBE && DIR_READ) [*8];
  endsequence
  a_reset_mid: assert property (disable iff (1'b0)
    RST |=> wipers == {4{`QWDP_WIPER_INIT}})
    else $error("wipers not at mid-scale after reset");
  a_shift_quiet: assert property (
    (!PORT_SELECT_PIN) [*6] |-> !SDA_OE)
    else $error("data line pulled in shift mode");
  a_pass_through: assert property (
    s_idle |-> SER_DOUT == SER_DIN)
    else $error("cascade out not following data in");
  a_load_inhibit: assert property (
    s_load |-> !SER_DOUT)
    else $error("cascade out active while loading");
  a_read_hold: assert property (
    s_read |-> $stable(wipers))
    else $error("wiper changed during shift read");
  a_wiper_fall: assert property (
    $changed(wipers) |-> (PORT_SELECT_PIN ? !$past(SCL_IN, 4)
      : !$past(SHIFT_CLK, 4)))
    else $error("wiper changed without a clock fall");
  a_sda_low_change: assert property (
    $changed(SDA_OE) |-> !SCL_IN && !$past(SCL_IN))
    else $error("data line moved while bus clock high");
  a_sda_hold_high: assert property (
    SCL_IN [*2] |-> $stable(SDA_OE))
    else $error("data drive changed in clock high phase");
endmodule
bind qwdp_top qwdp_top_mon qwdp_top_mon_i
(
  .CORE_CLK(CORE_CLK), .RST(RST), .PORT_SELECT_PIN(PORT_SELECT_PIN),
  .XFER_STROBE(XFER_STROBE), .SHIFT_CLK(SHIFT_CLK), .SER_DIN(SER_DIN),
  .DIR_READ(DIR_READ), .SER_DOUT(SER_DOUT), .SCL_IN(SCL_IN),
  .SDA_OE(SDA_OE), .WIPER0(WIPER0), .WIPER1(WIPER1), .WIPER2(WIPER2),
  .WIPER3(WIPER3)
);

/* qwdp_host.sv */
`timescale 1ns/100ps
module qwdp_host
(
  input  wire clk,
  input  wire sda,
  input  wire dout,
  output reg  strobe = 1'b0,
  output reg  sck = 1'b0,
  output reg  din = 1'b0,
  output reg  dir = 1'b0,
  output reg  scl = 1'b1,
  output reg  sda_low = 1'b0
);
  // wait some core clock edges
  task hold(input integer n);
    repeat (n) @(posedge clk);
  endtask
  // idle data-in level for pass-through
  task set_din(input b);
    din <= b;
  endtask
  // strobe change, direction settled well before
  task sh_strobe(input on, input d);
  begin
    dir <= d;
    hold(5);
    strobe <= on;
    hold(8);
  end
  endtask
  // one byte msb first, 80 ns per bit; a cascade bit lags its fall
  // by the pin sync, so it is taken one bit period later
  task sh_byte(input [7:0] b, output [7:0] r);
    integer i;
  begin
    for (i = 7; i >= 0; i = i - 1)
    begin
      din <= dir ? ~din : b[i];
      hold(2);
      sck <= 1'b1;
      hold(4);
      sck <= 1'b0;
      hold(2);
      if (i < 7)
        r[i+1] = dout;
    end
    hold(8);
    r[0] = dout;
  end
  endtask
  // start (stop=0) or stop (stop=1)
  task tw_cond(input stop);
  begin
    sda_low <= stop;
    hold(8);
    scl <= 1'b1;
    hold(8);
    sda_low <= !stop;
    hold(8);
    scl <= stop;
    hold(8);
  end
  endtask
  // eight bits and acknowledge slot; wire level taken mid-high
  task tw_byte(input [8:0] b, output [8:0] r);
    integer i;
  begin
    for (i = 8; i >= 0; i = i - 1)
    begin
      sda_low <= !b[i];
      hold(4);
      scl <= 1'b1;
      hold(4);
      r[i] = sda;
      hold(4);
      scl <= 1'b0;
      hold(8);
    end
  end
  endtask
endmodule

/* testbench.sv */
`timescale 1ns/100ps
`include "qwdp_regs.vh"
module testbench;
  // device type code, value is arbitrary
  localparam [3:0] dev_type = 4'hA;
  reg              clk = 1'b0;
  reg              rst = 1'b1;
  reg              psel = 1'b0;
  reg  [2:0]       adr = 3'h0;
  wire             strobe, sck, din, dir, scl, sda_low, dout, oe, sdo;
  wire [5:0]       wip [0:3];
  // open-drain wire with pull-up
  wire             sda = !sda_low && (oe ? sdo : 1'b1);
  integer          errors = 0;
  integer          samples_checked = 0;
  integer          model [0:3];
  integer          k;
  reg  [7:0]       r;
  reg  [8:0]       q;
  qwdp_top #(.DEV_TYPE(dev_type)) qwdp_top_i
  (
    .CORE_CLK(clk), .RST(rst), .PORT_SELECT_PIN(psel), .XFER_STROBE(strobe),
    .SHIFT_CLK(sck), .SER_DIN(din), .DIR_READ(dir), .SER_DOUT(dout),
    .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(sdo), .SDA_OE(oe),
    .DEVICE_SELECT_BIT0(adr[0]), .DEVICE_SELECT_BIT1(adr[1]),
    .DEVICE_SELECT_BIT2(adr[2]), .WIPER0(wip[0]), .WIPER1(wip[1]),
    .WIPER2(wip[2]), .WIPER3(wip[3])
  );
  qwdp_host qwdp_host_i
  (
    .clk(clk), .sda(sda), .dout(dout), .strobe(strobe), .sck(sck),
    .din(din), .dir(dir), .scl(scl), .sda_low(sda_low)
  );
  // 100 MHz core clock
  initial
    forever #5 clk = ~clk;
  // compare and count
  task check(input string nm, input [7:0] e, input [7:0] g);
  begin
    samples_checked = samples_checked + 1;
    if (g !== e)
    begin
      errors = errors + 1;
      $display("mismatch %0s expected %h seen %h", nm, e, g);
    end
  end
  endtask
  // all wipers against the model
  task check_wipers;
    for (k = 0; k < 4; k = k + 1)
      check("wiper", model[k][7:0], {2'h0, wip[k]});
  endtask
  // verdict and end of run
  task close_out;
  begin
    $display("checked %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  end
  endtask
  // hang guard
  initial
  begin
    repeat (90000) @(posedge clk);
    errors = errors + 1;
    close_out;
  end
  // main sequence
  initial
  begin
    r = $urandom(8647);
    adr <= $urandom;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    qwdp_host_i.hold(6);
    for (k = 0; k < 4; k = k + 1)
      model[k] = 32;
    check_wipers;
    $display("test reset done");
    // load four bytes, pots in descending order, top value first
    qwdp_host_i.sh_strobe(1'b1, 1'b0);
    for (k = 0; k < 4; k = k + 1)
    begin
      r = $urandom;
      r[7:6] = 2'h3 - k[1:0];
      if (k == 0)
        r[5:0] = 6'h3F;
      qwdp_host_i.sh_byte(r, q[7:0]);
      model[r[7:6]] = r[5:0];
      check("dout_load", 8'h00, {7'h0, dout});
    end
    qwdp_host_i.sh_strobe(1'b0, 1'b0);
    check_wipers;
    for (k = 0; k < 2; k = k + 1)
    begin
      qwdp_host_i.set_din(!k[0]);
      qwdp_host_i.hold(8);
      check("dout_thru", {7'h0, !k[0]}, {7'h0, dout});
    end
    $display("test shift write done");
    // read five bytes, wraps back to pot 0
    qwdp_host_i.sh_strobe(1'b1, 1'b1);
    for (k = 0; k < 5; k = k + 1)
    begin
      qwdp_host_i.sh_byte(8'h00, r);
      check("shift_rd", {k[1:0], model[k % 4][5:0]}, r);
    end
    qwdp_host_i.sh_strobe(1'b0, 1'b1);
    $display("test shift read done");
    // two-wire: foreign address ignored
    psel <= 1'b1;
    qwdp_host_i.hold(8);
    qwdp_host_i.tw_cond(1'b0);
    qwdp_host_i.tw_byte({dev_type, adr ^ 3'h1, 1'b0, 1'b1}, q);
    check("foreign_ack", 8'h01, {7'h0, q[0]});
    qwdp_host_i.tw_byte({8'h00, 1'b1}, q);
    check("foreign_dat", 8'h01, {7'h0, q[0]});
    qwdp_host_i.tw_cond(1'b1);
    check_wipers;
    // own address: three data bytes, fresh straps
    adr <= $urandom;
    qwdp_host_i.tw_cond(1'b0);
    qwdp_host_i.tw_byte({dev_type, adr, 1'b0, 1'b1}, q);
    check("ctl_ack", 8'h00, {7'h0, q[0]});
    for (k = 0; k < 3; k = k + 1)
    begin
      r = $urandom;
      qwdp_host_i.tw_byte({r, 1'b1}, q);
      check("dat_ack", 8'h00, {7'h0, q[0]});
      model[r[7:6]] = r[5:0];
    end
    check_wipers;
    // repeated start into a read, last byte not acknowledged
    qwdp_host_i.tw_cond(1'b0);
    qwdp_host_i.tw_byte({dev_type, adr, 1'b1, 1'b1}, q);
    check("rd_ack", 8'h00, {7'h0, q[0]});
    for (k = 0; k < 3; k = k + 1)
    begin
      qwdp_host_i.tw_byte({8'hFF, k == 2}, q);
      check("bus_rd", {k[1:0], model[k][5:0]}, q[8:1]);
    end
    qwdp_host_i.hold(8);
    check("released", 8'h01, {7'h0, sda});
    qwdp_host_i.tw_cond(1'b1);
    check("dout_bus", 8'h00, {7'h0, dout});
    $display("test two-wire done");
    close_out;
  end
endmodule
